/* File: rtl/prm_pkg.sv */
// Notes on behaviour
// - increments per rotation = 400*num/den
// - range end write resets both travel limits
// - range end default 102400, that is 256 rotations
// - host picks end 3..253 rotations above position
// - rotation sense codes 16 cw, 23 ccw
// - sense change restores offset, end, limits
// - scale change rescales all dependent values
// - preset sets position, offset takes difference
// - offset change shifts position, end, limits
// - delivery: offset 0, num and den 400
// - delivery mid 51200, min 1200, max 101200
// - host writes parameters in recommended order
// - settings persist only after save command; save copies to nv_ff, which reset clears and nothing reads back
// - host keeps den 400, tunes numerator
// - end shift wraps position by 256 rotations
// - computed bounds rounded to nearest integer
package prm_pkg;

   // ****************************************************
   // parameter indexes on the link
   // ****************************************************
   localparam logic [3:0]  IX_DIR    = 4'h0;
   localparam logic [3:0]  IX_NUM    = 4'h1;
   localparam logic [3:0]  IX_DEN    = 4'h2;
   localparam logic [3:0]  IX_REF    = 4'h3;
   localparam logic [3:0]  IX_POS    = 4'h4;
   localparam logic [3:0]  IX_END    = 4'h5;
   localparam logic [3:0]  IX_HI     = 4'h6;
   localparam logic [3:0]  IX_LO     = 4'h7;
   localparam logic [3:0]  IX_WIN    = 4'h8;
   localparam logic [3:0]  IX_LOOP   = 4'h9;
   localparam logic [3:0]  IX_MID    = 4'hA;
   localparam logic [3:0]  IX_IPR    = 4'hB;
   localparam logic [3:0]  IX_SAVE   = 4'hC;
   localparam logic [3:0]  RANK_NONE = 4'hF;
   localparam int          NV_N      = 9;

   // ****************************************************
   // scaling and range figures
   // ****************************************************
   localparam logic [15:0] STEPS_ROT = 16'h0190;
   localparam logic [15:0] SCALE_DEF = 16'h0190;
   localparam logic [15:0] ROT_HI    = 16'h0003;
   localparam logic [15:0] ROT_LO    = 16'h00FD;
   localparam logic [15:0] ROT_SPAN  = 16'h0100;
   localparam logic [15:0] ROT_MID   = 16'h0080;
   localparam logic [16:0] ENC_MAX   = 17'h18FFF;
   localparam logic [7:0]  DIR_CW    = 8'h10;
   localparam logic [7:0]  DIR_CCW   = 8'h17;
   localparam logic [31:0] REF_DEF   = 32'h0000_0000;
   localparam logic [31:0] END_DEF   = 32'h0001_9000;
   localparam logic [31:0] HI_DEF    = END_DEF - 32'(ROT_HI) * 32'(STEPS_ROT);
   localparam logic [31:0] LO_DEF    = END_DEF - 32'(ROT_LO) * 32'(STEPS_ROT);
   localparam logic [31:0] WIN_DEF   = 32'h0000_000A;
   localparam logic [31:0] LOOP_DEF  = 32'h0000_0190;

   // ****************************************************
   // host register map and fields
   // ****************************************************
   localparam logic [7:0]  A_CMD     = 8'h00;
   localparam logic [7:0]  A_WDATA   = 8'h04;
   localparam logic [7:0]  A_RDATA   = 8'h08;
   localparam logic [7:0]  A_STAT    = 8'h0C;
   localparam int          CMD_GO    = 0;
   localparam int          CMD_WR    = 1;
   localparam int          CMD_IDX   = 4;
   localparam int          ST_BUSY   = 0;
   localparam int          ST_ERR    = 1;
   localparam int          ST_DONE   = 2;
   localparam int          ST_ORDER  = 3;
   localparam int          ST_DENADV = 4;

   typedef enum logic [1:0] {
      D_IDLE = 2'b01,
      D_ACK  = 2'b10
   } prm_dst_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'b01,
      H_WAIT = 2'b10
   } prm_hst_t;

endpackage

/* File: rtl/prm_if.sv */
`timescale 1ns/1ps
interface prm_if;
   logic        req;
   logic        wr;
   logic [3:0]  idx;
   logic [31:0] wdata;
   logic        ack;
   logic        err;
   logic [31:0] rdata;

   modport dev  (input req, wr, idx, wdata, output ack, err, rdata);
   modport host (output req, wr, idx, wdata, input ack, err, rdata);
endinterface

/* File: rtl/prm_dev.sv */
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module prm_dev
   import prm_pkg::*;
(
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // parameter link
   prm_if.dev                      lnk,
   // encoder
   input  wire logic [16:0]        enc_pos,
   // drive side
   output logic signed [31:0]      act_pos,
   output logic signed [31:0]      lim_hi,
   output logic signed [31:0]      lim_lo,
   output logic signed [31:0]      inc_rot,
   output logic [31:0]             win,
   output logic [31:0]             loop_len,
   output logic                    dir_ccw,
   output logic                    saved
);

   // ****************************************************
   // arithmetic helpers
   // ****************************************************
   // v*n/d rounded half away from zero
   function automatic logic signed [31:0] mdiv(input logic signed [31:0] v,
                                               input logic [31:0] n, input logic [31:0] d);
      logic signed [63:0] p;
      logic signed [63:0] dd;
      p  = 64'(v) * $signed(64'(n));
      dd = $signed(64'(d));
      if (p < 0) begin
         p = (p <<< 1) - dd;
      end else begin
         p = (p <<< 1) + dd;
      end
      mdiv = 32'(p / (dd <<< 1));
   endfunction

   // increments in k rotations at scale n/d
   function automatic logic signed [31:0] rots(input logic [15:0] k, input logic [15:0] n,
                                               input logic [15:0] d);
      rots = mdiv($signed(32'(k) * 32'(STEPS_ROT)), 32'(n), 32'(d));
   endfunction

   // ****************************************************
   // state
   // ****************************************************
   prm_dst_t           st_ff,   nxt_st;
   logic [7:0]         dir_ff,  nxt_dir;
   logic [15:0]        num_ff,  nxt_num;
   logic [15:0]        den_ff,  nxt_den;
   logic signed [31:0] ref_ff,  nxt_ref;
   logic signed [31:0] end_ff,  nxt_end;
   logic signed [31:0] hi_ff,   nxt_hi;
   logic signed [31:0] lo_ff,   nxt_lo;
   logic signed [31:0] win_ff,  nxt_win;
   logic signed [31:0] loop_ff, nxt_loop;
   logic signed [31:0] wrap_ff, nxt_wrap;
   logic [31:0]        rd_ff,   nxt_rd;
   logic               err_ff,  nxt_err;
   logic               sv_ff,   nxt_sv;
   logic signed [31:0] act_ff,  nxt_act;
   logic [31:0]        nv_ff    [NV_N];
   logic [31:0]        nxt_nv   [NV_N];

   logic [16:0]        raw;
   logic signed [31:0] base;
   logic signed [31:0] actc;

   // ****************************************************
   // position mapping
   // ****************************************************
   always_comb begin
      raw  = (dir_ff == DIR_CCW) ? ENC_MAX - enc_pos : enc_pos;
      base = mdiv($signed(32'(raw)), 32'(num_ff), 32'(den_ff));
      actc = base + wrap_ff + ref_ff;
   end

   // ****************************************************
   // parameter access
   // ****************************************************
   always_comb begin
      logic signed [31:0] newref;
      logic signed [31:0] dlt;
      logic signed [31:0] span;
      logic [31:0]        fn;
      logic [31:0]        fd;
      logic [15:0]        wn;
      logic [15:0]        wd;
      newref   = ref_ff;
      dlt      = '0;
      span     = '0;
      fn       = '0;
      fd       = '0;
      wn       = num_ff;
      wd       = den_ff;
      nxt_st   = st_ff;
      nxt_dir  = dir_ff;
      nxt_num  = num_ff;
      nxt_den  = den_ff;
      nxt_ref  = ref_ff;
      nxt_end  = end_ff;
      nxt_hi   = hi_ff;
      nxt_lo   = lo_ff;
      nxt_win  = win_ff;
      nxt_loop = loop_ff;
      nxt_wrap = wrap_ff;
      nxt_rd   = rd_ff;
      nxt_err  = err_ff;
      nxt_sv   = 1'b0;
      nxt_act  = actc;
      for (int i = 0; i < NV_N; i++) begin
         nxt_nv[i] = nv_ff[i];
      end
      case (st_ff)
         D_IDLE: begin
            if (lnk.req) begin
               nxt_st  = D_ACK;
               nxt_err = 1'b0;
               nxt_rd  = '0;
               if (!lnk.wr) begin
                  case (lnk.idx)
                     IX_DIR:  nxt_rd = 32'(dir_ff);
                     IX_NUM:  nxt_rd = 32'(num_ff);
                     IX_DEN:  nxt_rd = 32'(den_ff);
                     IX_REF:  nxt_rd = ref_ff;
                     IX_POS:  nxt_rd = actc;
                     IX_END:  nxt_rd = end_ff;
                     IX_HI:   nxt_rd = hi_ff;
                     IX_LO:   nxt_rd = lo_ff;
                     IX_WIN:  nxt_rd = win_ff;
                     IX_LOOP: nxt_rd = loop_ff;
                     IX_MID:  nxt_rd = end_ff - rots(ROT_MID, num_ff, den_ff);
                     IX_IPR:  nxt_rd = rots(16'h0001, num_ff, den_ff);
                     default: nxt_err = 1'b1;
                  endcase
               end else begin
                  wn = lnk.wdata[15:0];
                  case (lnk.idx)
                     IX_DIR: begin
                        if (lnk.wdata != 32'(DIR_CW) && lnk.wdata != 32'(DIR_CCW)) begin
                           nxt_err = 1'b1;
                        end else if (lnk.wdata[7:0] != dir_ff) begin
                           nxt_dir  = lnk.wdata[7:0];
                           nxt_ref  = REF_DEF;
                           nxt_end  = END_DEF;
                           nxt_hi   = HI_DEF;
                           nxt_lo   = LO_DEF;
                           nxt_wrap = '0;
                        end
                     end
                     IX_NUM, IX_DEN: begin
                        if (lnk.idx == IX_DEN) begin
                           wn = num_ff;
                           wd = lnk.wdata[15:0];
                        end
                        // zero or oversized scale would break the divider
                        if (wn == 16'h0000 || wd == 16'h0000 || lnk.wdata[31:16] != 16'h0000) begin
                           nxt_err = 1'b1;
                        end else begin
                           fn       = 32'(wn) * 32'(den_ff);
                           fd       = 32'(num_ff) * 32'(wd);
                           nxt_num  = wn;
                           nxt_den  = wd;
                           nxt_ref  = mdiv(ref_ff, fn, fd);
                           nxt_end  = mdiv(end_ff, fn, fd);
                           nxt_hi   = mdiv(hi_ff, fn, fd);
                           nxt_lo   = mdiv(lo_ff, fn, fd);
                           nxt_win  = mdiv(win_ff, fn, fd);
                           nxt_loop = mdiv(loop_ff, fn, fd);
                           nxt_wrap = mdiv(wrap_ff, fn, fd);
                        end
                     end
                     IX_REF, IX_POS: begin
                        if (lnk.idx == IX_POS) begin
                           newref = lnk.wdata - base - wrap_ff;
                        end else begin
                           newref = lnk.wdata;
                        end
                        dlt     = newref - ref_ff;
                        nxt_ref = newref;
                        nxt_end = end_ff + dlt;
                        nxt_hi  = hi_ff + dlt;
                        nxt_lo  = lo_ff + dlt;
                     end
                     IX_END: begin
                        nxt_end = lnk.wdata;
                        nxt_hi  = lnk.wdata - rots(ROT_HI, num_ff, den_ff);
                        nxt_lo  = lnk.wdata - rots(ROT_LO, num_ff, den_ff);
                        span    = rots(ROT_SPAN, num_ff, den_ff);
                        if (actc > $signed(lnk.wdata)) begin
                           nxt_wrap = wrap_ff - span;
                        end else if (actc < $signed(lnk.wdata) - span) begin
                           nxt_wrap = wrap_ff + span;
                        end
                     end
                     IX_HI:   nxt_hi   = lnk.wdata;
                     IX_LO:   nxt_lo   = lnk.wdata;
                     IX_WIN:  nxt_win  = lnk.wdata;
                     IX_LOOP: nxt_loop = lnk.wdata;
                     IX_SAVE: begin
                        nxt_nv[0] = 32'(dir_ff);
                        nxt_nv[1] = 32'(num_ff);
                        nxt_nv[2] = 32'(den_ff);
                        nxt_nv[3] = ref_ff;
                        nxt_nv[4] = end_ff;
                        nxt_nv[5] = hi_ff;
                        nxt_nv[6] = lo_ff;
                        nxt_nv[7] = win_ff;
                        nxt_nv[8] = loop_ff;
                        nxt_sv    = 1'b1;
                     end
                     default: nxt_err = 1'b1;
                  endcase
               end
            end
         end
         D_ACK:   nxt_st = D_IDLE;
         default: nxt_st = D_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff   <= D_IDLE;
         dir_ff  <= DIR_CW;
         num_ff  <= SCALE_DEF;
         den_ff  <= SCALE_DEF;
         ref_ff  <= REF_DEF;
         end_ff  <= END_DEF;
         hi_ff   <= HI_DEF;
         lo_ff   <= LO_DEF;
         win_ff  <= WIN_DEF;
         loop_ff <= LOOP_DEF;
         wrap_ff <= '0;
         rd_ff   <= '0;
         err_ff  <= 1'b0;
         sv_ff   <= 1'b0;
         act_ff  <= '0;
         for (int i = 0; i < NV_N; i++) begin
            nv_ff[i] <= '0;
         end
      end else begin
         st_ff   <= nxt_st;
         dir_ff  <= nxt_dir;
         num_ff  <= nxt_num;
         den_ff  <= nxt_den;
         ref_ff  <= nxt_ref;
         end_ff  <= nxt_end;
         hi_ff   <= nxt_hi;
         lo_ff   <= nxt_lo;
         win_ff  <= nxt_win;
         loop_ff <= nxt_loop;
         wrap_ff <= nxt_wrap;
         rd_ff   <= nxt_rd;
         err_ff  <= nxt_err;
         sv_ff   <= nxt_sv;
         act_ff  <= nxt_act;
         for (int i = 0; i < NV_N; i++) begin
            nv_ff[i] <= nxt_nv[i];
         end
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   // ack comes one cycle after the take with parameter flops updated; act_ff follows one cycle later
   assign lnk.ack   = (st_ff == D_ACK);
   assign lnk.err   = err_ff;
   assign lnk.rdata = rd_ff;
   assign act_pos   = act_ff;
   assign lim_hi    = hi_ff;
   assign lim_lo    = lo_ff;
   assign inc_rot   = rots(16'h0001, num_ff, den_ff);
   assign win       = win_ff;
   assign loop_len  = loop_ff;
   assign dir_ccw   = (dir_ff == DIR_CCW);
   assign saved     = sv_ff;

endmodule

/* File: rtl/prm_host.sv */
`timescale 1ns/1ps
module prm_host
   import prm_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // parameter link
   prm_if.host              lnk
);

   // ****************************************************
   // helpers
   // ****************************************************
   // position of an index in the adjustment-free write order
   function automatic logic [3:0] rank(input logic [3:0] ix);
      case (ix)
         IX_DIR:         rank = 4'h0;
         IX_NUM:         rank = 4'h1;
         IX_DEN:         rank = 4'h2;
         IX_REF, IX_POS: rank = 4'h3;
         IX_END:         rank = 4'h4;
         IX_HI:          rank = 4'h5;
         IX_LO:          rank = 4'h6;
         IX_WIN:         rank = 4'h7;
         IX_LOOP:        rank = 4'h8;
         default:        rank = RANK_NONE;
      endcase
   endfunction

   // ****************************************************
   // state
   // ****************************************************
   prm_hst_t    st_ff,   nxt_st;
   logic        req_ff,  nxt_req;
   logic        wr_ff,   nxt_wr;
   logic [3:0]  idx_ff,  nxt_idx;
   logic [31:0] wbuf_ff, nxt_wbuf;
   logic [31:0] rd_ff,   nxt_rd;
   logic        err_ff,  nxt_err;
   logic        done_ff, nxt_done;
   logic        ord_ff,  nxt_ord;
   logic        adv_ff,  nxt_adv;
   logic [3:0]  rk_ff,   nxt_rk;

   logic        acc;
   logic        go;
   logic        mapped;
   logic [3:0]  cidx;

   always_comb begin
      acc    = psel & penable & pwrite;
      mapped = (paddr == A_CMD) || (paddr == A_WDATA) || (paddr == A_RDATA) || (paddr == A_STAT);
      cidx   = pwdata[CMD_IDX +: 4];
      go     = acc && (paddr == A_CMD) && pwdata[CMD_GO] && (st_ff == H_IDLE);
   end

   always_comb begin
      nxt_st   = st_ff;
      nxt_req  = req_ff;
      nxt_wr   = wr_ff;
      nxt_idx  = idx_ff;
      nxt_wbuf = wbuf_ff;
      nxt_rd   = rd_ff;
      nxt_err  = err_ff;
      nxt_done = done_ff;
      nxt_ord  = ord_ff;
      nxt_adv  = adv_ff;
      nxt_rk   = rk_ff;
      if (acc && paddr == A_WDATA) begin
         nxt_wbuf = pwdata;
      end
      // clears first so that a same-cycle set wins
      if (acc && paddr == A_STAT) begin
         nxt_ord = ord_ff & ~pwdata[ST_ORDER];
         nxt_adv = adv_ff & ~pwdata[ST_DENADV];
      end
      case (st_ff)
         H_IDLE: begin
            if (go) begin
               nxt_st   = H_WAIT;
               nxt_req  = 1'b1;
               nxt_wr   = pwdata[CMD_WR];
               nxt_idx  = cidx;
               nxt_done = 1'b0;
               if (pwdata[CMD_WR] && rank(cidx) != RANK_NONE) begin
                  if (rank(cidx) != 4'h0 && rank(cidx) < rk_ff) begin
                     nxt_ord = 1'b1;
                  end
                  nxt_rk = rank(cidx);
               end
               if (pwdata[CMD_WR] && cidx == IX_DEN && wbuf_ff != 32'(SCALE_DEF)) begin
                  nxt_adv = 1'b1;
               end
            end
         end
         H_WAIT: begin
            if (lnk.ack) begin
               nxt_st   = H_IDLE;
               nxt_req  = 1'b0;
               nxt_rd   = lnk.rdata;
               nxt_err  = lnk.err;
               nxt_done = 1'b1;
            end
         end
         default: nxt_st = H_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff   <= H_IDLE;
         req_ff  <= 1'b0;
         wr_ff   <= 1'b0;
         idx_ff  <= '0;
         wbuf_ff <= '0;
         rd_ff   <= '0;
         err_ff  <= 1'b0;
         done_ff <= 1'b0;
         ord_ff  <= 1'b0;
         adv_ff  <= 1'b0;
         rk_ff   <= '0;
      end else begin
         st_ff   <= nxt_st;
         req_ff  <= nxt_req;
         wr_ff   <= nxt_wr;
         idx_ff  <= nxt_idx;
         wbuf_ff <= nxt_wbuf;
         rd_ff   <= nxt_rd;
         err_ff  <= nxt_err;
         done_ff <= nxt_done;
         ord_ff  <= nxt_ord;
         adv_ff  <= nxt_adv;
         rk_ff   <= nxt_rk;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   always_comb begin
      case (paddr)
         A_CMD:   prdata = {24'h000000, idx_ff, 2'b00, wr_ff, req_ff};
         A_WDATA: prdata = wbuf_ff;
         A_RDATA: prdata = rd_ff;
         A_STAT:  prdata = {27'h0000000, adv_ff, ord_ff, done_ff, err_ff, (st_ff == H_WAIT)};
         default: prdata = '0;
      endcase
   end

   // link write data comes from wbuf_ff, which an A_WDATA write still changes while the link transfer runs
   assign lnk.req   = req_ff;
   assign lnk.wr    = wr_ff;
   assign lnk.idx   = idx_ff;
   assign lnk.wdata = wbuf_ff;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~mapped;

endmodule

/* File: dv/prm_sva.sv */
`timescale 1ns/1ps
module prm_sva
   import prm_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // link
   input wire logic        req,
   input wire logic        wr,
   input wire logic [3:0]  idx,
   input wire logic [31:0] wdata,
   input wire logic        ack,
   input wire logic        err,
   input wire logic [31:0] rdata
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****
   // answer timing
   // ****
   a_ack_after_take: assert property ($rose(req) |=> ack) else $error("ack late");
   a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack too long");
   a_ack_needs_req: assert property (ack |-> req && $past(req)) else $error("ack without req");
   a_req_held: assert property (req && !ack |=> req && $stable({wr, idx, wdata})) else $error("req moved");
   a_req_drop: assert property (ack |=> !req) else $error("req kept");
   a_answer_stands: assert property (!req |=> $stable({rdata, err})) else $error("answer moved");
   // ****
   // refusals
   // ****
   a_sense_code: assert property (ack && wr && idx == IX_DIR |->
      err == !(wdata == 32'(DIR_CW) || wdata == 32'(DIR_CCW))) else $error("sense code");
   a_scale_zero: assert property (ack && wr && (idx == IX_NUM || idx == IX_DEN) && wdata == 32'h0 |-> err)
      else $error("zero scale taken");
   a_ro_refused: assert property (ack && ((wr && (idx == IX_MID || idx == IX_IPR)) || (!wr && idx == IX_SAVE))
      |-> err) else $error("refusal missing");
   c_write: cover property (ack && wr && !err);
   c_read: cover property (ack && !wr);
   c_refused: cover property (ack && err);
endmodule

/* File: dv/prm_bench.sv */
`timescale 1ns/1ps
module prm_bench
   import prm_pkg::*;
;
   logic               pclk = 1'b0;
   logic               presetn = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0;
   logic [16:0]        enc_pos = 17'h0C800;
   logic [31:0]        prdata, win, loop_len;
   logic               pready, pslverr, dir_ccw, saved;
   logic signed [31:0] act_pos, lim_hi, lim_lo, inc_rot;
   int                 n_errors = 0, num_checks = 0, n_saved = 0;
   prm_if lnk ();
   always #4 pclk = ~pclk;
   always @(posedge pclk) if (saved === 1'b1) n_saved <= n_saved + 1;
   prm_dev i_prm_dev (.pclk, .presetn, .lnk(lnk), .enc_pos, .act_pos, .lim_hi, .lim_lo, .inc_rot, .win,
                      .loop_len, .dir_ccw, .saved);
   prm_host i_prm_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                        .pslverr, .lnk(lnk));
   prm_sva i_prm_sva (.pclk, .presetn, .req(lnk.req), .wr(lnk.wr), .idx(lnk.idx), .wdata(lnk.wdata),
                      .ack(lnk.ack), .err(lnk.err), .rdata(lnk.rdata));
   // ****
   // tasks
   // ****
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang();
      n_errors++;
      $display("Error at %0t: no answer", $time);
      complete_run();
   endtask
   // bounded wait, pready tied high today but not assumed
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) hang();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic acc(input logic w, input logic [3:0] x, input logic [31:0] d, input logic xe,
                      output logic [31:0] q);
      logic [31:0] s;
      logic        pe;
      int          i;
      apb(1'b1, A_WDATA, d, s, pe);
      apb(1'b1, A_CMD, {24'h0, x, 2'b00, w, 1'b1}, s, pe);
      for (i = 0; i < 20; i++) begin
         apb(1'b0, A_STAT, 32'h0, s, pe);
         if (s[ST_DONE] === 1'b1) break;
      end
      if (i == 20) hang();
      chk(32'(s[ST_ERR]), 32'(xe));
      apb(1'b0, A_RDATA, 32'h0, q, pe);
   endtask
   task automatic rd(input logic [3:0] x, input logic [31:0] exp);
      logic [31:0] q;
      acc(1'b0, x, 32'h0, 1'b0, q);
      chk(q, exp);
   endtask
   task automatic wr(input logic [3:0] x, input logic [31:0] d, input logic xe);
      logic [31:0] q;
      acc(1'b1, x, d, xe, q);
   endtask
   // one status flag of the host against its expected level
   task automatic stat(input int b, input logic x);
      logic [31:0] s;
      logic        pe;
      apb(1'b0, A_STAT, 32'h0, s, pe);
      chk(32'(s[b]), 32'(x));
   endtask
   // limits follow the range end at 3 and 253 rotations
   task automatic rng(input logic [31:0] e, input logic [31:0] inc);
      rd(IX_END, e);
      rd(IX_HI, e - 32'(ROT_HI) * inc);
      rd(IX_LO, e - 32'(ROT_LO) * inc);
      chk(lim_hi, e - 32'(ROT_HI) * inc);
      chk(lim_lo, e - 32'(ROT_LO) * inc);
   endtask
   // ****
   // sequence
   // ****
   initial begin
      logic [31:0] q;
      logic        e;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(IX_DIR, 32'(DIR_CW));
      rd(IX_NUM, 32'h190);
      rd(IX_DEN, 32'h190);
      rd(IX_REF, 32'h0);
      rd(IX_POS, 32'hC800);
      rd(IX_MID, 32'hC800);
      rd(IX_IPR, 32'h190);
      chk(inc_rot, 32'h190);
      rng(END_DEF, 32'h190);
      $display("delivery test end");
      wr(IX_END, 32'h9C40, 1'b0);
      rng(32'h9C40, 32'h190);
      chk(act_pos, 32'hFFFF_3800);
      wr(IX_END, 32'h0002_5350, 1'b0);
      rng(32'h0002_5350, 32'h190);
      chk(act_pos, 32'hC800);
      $display("range test end");
      wr(IX_POS, 32'h3E8, 1'b0);
      stat(ST_ORDER, 1'b1);
      apb(1'b1, A_STAT, 32'h1 << ST_ORDER, q, e);
      stat(ST_ORDER, 1'b0);
      chk(act_pos, 32'h3E8);
      rd(IX_REF, 32'h3E8 - 32'hC800);
      rng(32'h0002_5350 - 32'hC800 + 32'h3E8, 32'h190);
      wr(IX_REF, 32'h0, 1'b0);
      chk(act_pos, 32'hC800);
      rng(32'h0002_5350, 32'h190);
      $display("reference test end");
      wr(IX_DIR, 32'h14, 1'b1);
      wr(IX_DIR, 32'(DIR_CCW), 1'b0);
      chk(32'(dir_ccw), 32'h1);
      chk(act_pos, 32'hC7FF);
      rng(END_DEF, 32'h190);
      wr(IX_DIR, 32'(DIR_CW), 1'b0);
      chk(32'(dir_ccw), 32'h0);
      $display("sense test end");
      wr(IX_NUM, 32'h0, 1'b1);
      wr(IX_NUM, 32'hC8, 1'b0);
      chk(inc_rot, 32'hC8);
      chk(act_pos, 32'h6400);
      chk(win, 32'h5);
      chk(loop_len, 32'hC8);
      rng(32'hC800, 32'hC8);
      wr(IX_DEN, 32'h3, 1'b0);
      chk(inc_rot, 32'h682B);
      chk(act_pos, 32'h0034_1555);
      stat(ST_DENADV, 1'b1);
      $display("scale test end");
      wr(IX_SAVE, 32'h0, 1'b0);
      chk(32'(n_saved), 32'h1);
      acc(1'b0, IX_SAVE, 32'h0, 1'b1, q);
      wr(IX_MID, 32'h0, 1'b1);
      apb(1'b0, 8'h10, 32'h0, q, e);
      chk(32'(e), 32'h1);
      $display("save test end");
      complete_run();
   end
endmodule
